// ---- design/rcfg_bank.sv ----
// Contract
// - Power-up reset loads every register with its default word.
// - Defaults: 0x0 is 0xbea41603, 0x9 is 0x00c00002, others as listed.
// - Lock indicator high while the synthesizer is locked, else low.
// - Shutdown input low switches every function off.
// - Digital mode shows sample bits 0 and 1 on each channel's pins.
// - Monitor enable routes I channel bit 1 and its inverse also to the monitor outputs.
// - Two-bit amplifier field selects high-band or low-band amplifier.
// - Data sampled on serial clock rise, read data driven on fall.
`timescale 1ns/1ns
`default_nettype none
module rcfg_bank
  import rcfg_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 2
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Serial port pins
  input wire logic sclk_i,
  input wire logic select_n_in_i,
  input wire logic serial_data_io_i,
  output logic serial_data_io_o,
  output logic serial_data_io_oe_o,
  // Control pins
  input wire logic power_off_n_in_i,
  input wire logic synth_locked_i,
  output logic lock_indicator_out_o,
  // Converter sample stream
  input wire rcfg_sample_s adc_sample_i,
  input wire logic adc_valid_i,
  output logic adc_ready_o,
  // Sample pins toward the receiver
  output logic inphase_sample_bit0_o,
  output logic inphase_sample_bit1_o,
  output logic quadrature_sample_bit0_o,
  output logic quadrature_sample_bit1_o,
  output logic sample_valid_o,
  input wire logic sample_ready_i,
  // Monitor pins
  output logic monitor_out_pos_o,
  output logic monitor_out_neg_o,
  // Amplifier enables
  output logic amp_high_en_o,
  output logic amp_low_en_o
);

  if (FIFO_DEPTH != 2) begin : g_depth_check
    $error("rcfg_bank serves a two-entry buffer only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic sclk_rise;
  logic sclk_fall;
  logic sel_n;
  logic sel_rise;
  logic sel_fall;
  logic sdi;
  logic power_on;
  logic locked;

  rcfg_pin_sync #(.RESET_LEVEL(1'b0)) u_sclk (
    .mclk_i(mclk_i), .rst_i(rst_i), .pin_i(sclk_i),
    .level_o(), .rise_o(sclk_rise), .fall_o(sclk_fall));
  rcfg_pin_sync #(.RESET_LEVEL(1'b1)) u_sel (
    .mclk_i(mclk_i), .rst_i(rst_i), .pin_i(select_n_in_i),
    .level_o(sel_n), .rise_o(sel_rise), .fall_o(sel_fall));
  rcfg_pin_sync #(.RESET_LEVEL(1'b0)) u_sdi (
    .mclk_i(mclk_i), .rst_i(rst_i), .pin_i(serial_data_io_i),
    .level_o(sdi), .rise_o(), .fall_o());
  rcfg_pin_sync #(.RESET_LEVEL(1'b0)) u_pwr (
    .mclk_i(mclk_i), .rst_i(rst_i), .pin_i(power_off_n_in_i),
    .level_o(power_on), .rise_o(), .fall_o());
  rcfg_pin_sync #(.RESET_LEVEL(1'b0)) u_lock (
    .mclk_i(mclk_i), .rst_i(rst_i), .pin_i(synth_locked_i),
    .level_o(locked), .rise_o(), .fall_o());

  ////////////////////////////////////////////////////////////////////////////
  // Serial shifter
  typedef enum logic [1:0] {
    SER_IDLE,
    SER_SHIFT,
    SER_DONE
  } rcfg_ser_e;

  rcfg_ser_e ser_q;
  rcfg_ser_e ser_d;
  logic [RCFG_CNT_W-1:0] cnt_q;
  logic [RCFG_CNT_W-1:0] cnt_d;
  logic [RCFG_FRAME_BITS-1:0] rx_q;
  logic [RCFG_FRAME_BITS-1:0] rx_d;
  logic [RCFG_DATA_BITS-1:0] tx_q;
  logic [RCFG_DATA_BITS-1:0] tx_d;
  logic sdo_q;
  logic sdo_d;
  logic oe_q;
  logic oe_d;
  logic commit;
  rcfg_bank_t bank_q;
  rcfg_bank_t bank_d;
  logic [RCFG_ADDR_W-1:0] hdr_addr;
  logic hdr_read;
  logic [RCFG_ADDR_W-1:0] wr_addr;
  rcfg_word_t rd_word;

  assign hdr_addr = rx_q[RCFG_HDR_BITS-1:RCFG_HDR_BITS-RCFG_ADDR_W];
  assign hdr_read = rx_q[RCFG_RW_POS];
  assign wr_addr = rx_q[RCFG_FRAME_BITS-1:RCFG_FRAME_BITS-RCFG_ADDR_W];

  always_comb begin
    rd_word = 32'h00000000;
    if (hdr_addr < RCFG_ADDR_W'(RCFG_NUM_REGS)) begin
      rd_word = bank_q[hdr_addr[3:0]];
    end
  end

  always_comb begin
    ser_d = ser_q;
    cnt_d = cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    commit = 1'b0;
    case (ser_q)
      SER_IDLE: begin
        oe_d = 1'b0;
        if (sel_fall && power_on) begin
          ser_d = SER_SHIFT;
          cnt_d = '0;
        end
      end
      SER_SHIFT: begin
        if (sclk_rise && cnt_q < RCFG_CNT_W'(RCFG_FRAME_BITS)) begin
          rx_d = {rx_q[RCFG_FRAME_BITS-2:0], sdi};
          cnt_d = cnt_q + 1'b1;
        end
        // Read word is captured once the header is complete
        if (cnt_q == RCFG_CNT_W'(RCFG_HDR_BITS) && hdr_read && !oe_q &&
            sclk_fall) begin
          sdo_d = rd_word[RCFG_DATA_BITS-1];
          tx_d = {rd_word[RCFG_DATA_BITS-2:0], 1'b0};
          oe_d = 1'b1;
        end else if (oe_q && sclk_fall) begin
          sdo_d = tx_q[RCFG_DATA_BITS-1];
          tx_d = {tx_q[RCFG_DATA_BITS-2:0], 1'b0};
        end
        if (sel_rise) begin
          ser_d = SER_DONE;
          oe_d = 1'b0;
        end
        if (!power_on) begin
          ser_d = SER_IDLE;
          oe_d = 1'b0;
        end
      end
      SER_DONE: begin
        // A short frame or a read leaves the bank untouched
        commit = (cnt_q == RCFG_CNT_W'(RCFG_FRAME_BITS)) &&
                 !rx_q[RCFG_DATA_BITS+RCFG_RW_POS];
        ser_d = SER_IDLE;
      end
      default: begin
        ser_d = SER_IDLE;
        oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ser_q <= SER_IDLE;
      cnt_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      ser_q <= ser_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
    end
  end

  assign serial_data_io_o = sdo_q;
  assign serial_data_io_oe_o = oe_q & ~sel_n;

  ////////////////////////////////////////////////////////////////////////////
  // Register bank
  // Reserved fields are stored as written; the host owns their fixed values
  always_comb begin
    bank_d = bank_q;
    if (commit && wr_addr < RCFG_ADDR_W'(RCFG_NUM_REGS)) begin
      bank_d[wr_addr[3:0]] = rx_q[RCFG_DATA_BITS-1:0];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bank_q <= RCFG_RESET_BANK;
    end else begin
      bank_q <= bank_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control decode
  rcfg_amp_e amp_mode;
  logic mon_en;
  logic dig_mode;

  assign amp_mode = rcfg_amp_e'(bank_q[0][AMP_SEL_LSB+1:AMP_SEL_LSB]);
  assign mon_en = bank_q[2][MON_EN_POS];
  assign dig_mode = bank_q[6][DIG_MODE_POS];

  logic amp_hi_q;
  logic amp_hi_d;
  logic amp_lo_q;
  logic amp_lo_d;
  logic lock_q;
  logic lock_d;

  always_comb begin
    amp_hi_d = 1'b0;
    amp_lo_d = 1'b0;
    case (amp_mode)
      AMP_HIGH_ONLY: amp_hi_d = power_on;
      AMP_LOW_ONLY: amp_lo_d = power_on;
      default: begin
        amp_hi_d = 1'b0;
        amp_lo_d = 1'b0;
      end
    endcase
    lock_d = locked & power_on;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      amp_hi_q <= 1'b0;
      amp_lo_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      amp_hi_q <= amp_hi_d;
      amp_lo_q <= amp_lo_d;
      lock_q <= lock_d;
    end
  end

  assign amp_high_en_o = amp_hi_q;
  assign amp_low_en_o = amp_lo_q;
  assign lock_indicator_out_o = lock_q;

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry sample buffer
  // A receiver stall backs up into the converter instead of dropping words
  rcfg_sample_s [1:0] buf_q;
  rcfg_sample_s [1:0] buf_d;
  logic [1:0] fill_q;
  logic [1:0] fill_d;
  logic push;
  logic pop;
  rcfg_sample_s pin_q;
  rcfg_sample_s pin_d;
  logic mon_pos_q;
  logic mon_pos_d;
  logic mon_neg_q;
  logic mon_neg_d;

  assign adc_ready_o = power_on && fill_q != 2'd2;
  assign sample_valid_o = power_on && fill_q != 2'd0;
  assign push = adc_valid_i && adc_ready_o;
  assign pop = sample_valid_o && sample_ready_i;

  always_comb begin
    buf_d = buf_q;
    fill_d = fill_q;
    pin_d = pin_q;
    mon_pos_d = mon_pos_q;
    mon_neg_d = mon_neg_q;
    if (pop) begin
      buf_d[0] = buf_q[1];
      fill_d = fill_q - 2'd1;
      pin_d = dig_mode ? buf_q[0] : '0;
      mon_pos_d = mon_en & buf_q[0].inphase[1];
      mon_neg_d = mon_en & ~buf_q[0].inphase[1];
    end
    if (push) begin
      buf_d[fill_d[0]] = adc_sample_i;
      fill_d = fill_d + 2'd1;
    end
    if (!mon_en) begin
      mon_pos_d = 1'b0;
      mon_neg_d = 1'b0;
    end
    if (!power_on) begin
      fill_d = 2'd0;
      pin_d = '0;
      mon_pos_d = 1'b0;
      mon_neg_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_q <= '0;
      fill_q <= 2'd0;
      pin_q <= '0;
      mon_pos_q <= 1'b0;
      mon_neg_q <= 1'b0;
    end else begin
      buf_q <= buf_d;
      fill_q <= fill_d;
      pin_q <= pin_d;
      mon_pos_q <= mon_pos_d;
      mon_neg_q <= mon_neg_d;
    end
  end

  assign inphase_sample_bit0_o = pin_q.inphase[0];
  assign inphase_sample_bit1_o = pin_q.inphase[1];
  assign quadrature_sample_bit0_o = pin_q.quadrature[0];
  assign quadrature_sample_bit1_o = pin_q.quadrature[1];
  assign monitor_out_pos_o = mon_pos_q;
  assign monitor_out_neg_o = mon_neg_q;

endmodule : rcfg_bank
`default_nettype wire

// ---- design/rcfg_pkg.sv ----
package rcfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame layout
  localparam int unsigned RCFG_ADDR_W = 12;
  localparam int unsigned RCFG_HDR_BITS = 16;
  localparam int unsigned RCFG_DATA_BITS = 32;
  localparam int unsigned RCFG_FRAME_BITS = RCFG_HDR_BITS + RCFG_DATA_BITS;
  localparam int unsigned RCFG_RW_POS = 3;
  localparam int unsigned RCFG_CNT_W = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int unsigned RCFG_NUM_REGS = 11;
  localparam logic [11:0] FRONT_END_CONFIG_A = 12'h000;
  localparam logic [11:0] FRONT_END_CONFIG_B = 12'h001;
  localparam logic [11:0] FRONT_END_CONFIG_C = 12'h002;
  localparam logic [11:0] SYNTH_CONFIG = 12'h003;
  localparam logic [11:0] SYNTH_INTEGER_DIVIDER = 12'h004;
  localparam logic [11:0] SYNTH_FRACTION_DIVIDER = 12'h005;
  localparam logic [11:0] SAMPLE_PORT_CONFIG = 12'h006;
  localparam logic [11:0] CLOCKING_CONFIG_A = 12'h007;
  localparam logic [11:0] TEST_CONFIG_A = 12'h008;
  localparam logic [11:0] TEST_CONFIG_B = 12'h009;
  localparam logic [11:0] CLOCKING_CONFIG_B = 12'h00a;

  typedef logic [31:0] rcfg_word_t;
  typedef rcfg_word_t [RCFG_NUM_REGS-1:0] rcfg_bank_t;

  localparam rcfg_bank_t RCFG_RESET_BANK = '{
    32'h010061b0, 32'h00c00002, 32'h01e0f401, 32'h010061b2,
    32'h08000000, 32'h08000070, 32'h00c00080, 32'h698c0008,
    32'h0eafa1dc, 32'h20550288, 32'hbea41603};

  ////////////////////////////////////////////////////////////////////////////
  // Fields steering the block
  localparam int unsigned AMP_SEL_LSB = 13;
  localparam int unsigned MON_EN_POS = 0;
  localparam int unsigned DIG_MODE_POS = 27;
  localparam int unsigned FIXED_A_LSB = 22;
  localparam logic [7:0] FIXED_A_VAL = 8'hfa;
  localparam int unsigned FIXED_B_LSB = 22;
  localparam logic [2:0] FIXED_B_VAL = 3'h3;

  typedef enum logic [1:0] {
    AMP_HIGH_ONLY,
    AMP_LOW_ONLY,
    AMP_BOTH_OFF,
    AMP_RESERVED
  } rcfg_amp_e;

  typedef struct packed {
    logic [1:0] inphase;
    logic [1:0] quadrature;
  } rcfg_sample_s;

endpackage : rcfg_pkg

// ---- design/rcfg_pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module rcfg_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Pin side
  input wire logic pin_i,
  // Filtered level and edges
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic meta_q;
  logic mid_q;
  logic last_q;
  logic level_q;
  logic level_d;

  // Level moves only when the two settled stages agree
  always_comb begin
    level_d = level_q;
    if (mid_q == last_q) begin
      level_d = last_q;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= RESET_LEVEL;
      mid_q <= RESET_LEVEL;
      last_q <= RESET_LEVEL;
      level_q <= RESET_LEVEL;
    end else begin
      meta_q <= pin_i;
      mid_q <= meta_q;
      last_q <= mid_q;
      level_q <= level_d;
    end
  end

  assign level_o = level_q;
  assign rise_o = level_d & ~level_q;
  assign fall_o = ~level_d & level_q;

endmodule : rcfg_pin_sync
`default_nettype wire

// ---- tb/rcfg_bank_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module rcfg_bank_properties (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Inputs
  input wire logic select_n_in_i,
  input wire logic power_off_n_in_i,
  input wire logic synth_locked_i,
  input wire logic sample_ready_i,
  // Outputs
  input wire logic serial_data_io_oe_o,
  input wire logic lock_indicator_out_o,
  input wire logic adc_ready_o,
  input wire logic sample_valid_o,
  input wire logic inphase_sample_bit0_o,
  input wire logic inphase_sample_bit1_o,
  input wire logic quadrature_sample_bit0_o,
  input wire logic quadrature_sample_bit1_o,
  input wire logic monitor_out_pos_o,
  input wire logic monitor_out_neg_o,
  input wire logic amp_high_en_o,
  input wire logic amp_low_en_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Pin synchronisers settle well inside 8 cycles
  chk_lock_low: assert property (
    (!synth_locked_i)[*8] |-> !lock_indicator_out_o)
    else $error("lock shown while unlocked");
  chk_lock_high: assert property (
    (synth_locked_i && power_off_n_in_i)[*8] |-> lock_indicator_out_o)
    else $error("lock missing while locked");
  chk_off_stream: assert property (
    (!power_off_n_in_i)[*8] |-> !adc_ready_o && !sample_valid_o)
    else $error("stream active in shutdown");
  chk_off_outputs: assert property (
    (!power_off_n_in_i)[*8] |=> !amp_high_en_o && !amp_low_en_o
    && !lock_indicator_out_o)
    else $error("outputs active in shutdown");
  chk_amp_exclusive: assert property (
    !(amp_high_en_o && amp_low_en_o))
    else $error("both amplifiers on");
  chk_mon_pair: assert property (
    !(monitor_out_pos_o && monitor_out_neg_o))
    else $error("monitor pair not complementary");
  chk_oe_idle: assert property (
    select_n_in_i[*8] |-> !serial_data_io_oe_o)
    else $error("data pin driven while idle");
  // Pins move only on a pop or in shutdown, so a stalled receiver sees a steady word
  chk_pins_hold: assert property (
    power_off_n_in_i[*8] ##0 !$past(sample_valid_o && sample_ready_i)
    |-> $stable({inphase_sample_bit0_o, inphase_sample_bit1_o,
    quadrature_sample_bit0_o, quadrature_sample_bit1_o}))
    else $error("sample pins moved without pop");
endmodule : rcfg_bank_properties
bind rcfg_bank rcfg_bank_properties rcfg_bank_properties_inst (.*);
`default_nettype wire

// ---- tb/rcfg_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module rcfg_host_model (
  // Serial pins
  output logic sclk_o,
  output logic select_n_o,
  output logic data_o,
  input wire logic data_i
);
  initial begin
    sclk_o = 1'b0;
    select_n_o = 1'b1;
    data_o = 1'b0;
  end
  // Clock stands still between frames; n below 48 cuts a frame short
  task automatic xfer(input logic rd, input logic [11:0] a,
    input logic [31:0] w, output logic [31:0] r, input int n);
    logic [47:0] f;
    f = {a, rd, 3'h0, w};
    r = '0;
    select_n_o = 1'b0;
    #80;
    for (int i = 47; i >= 48 - n; i--) begin
      // Released line toggles so a stale level cannot pass
      data_o = (rd && i < 32) ? ~data_o : f[i];
      #80 sclk_o = 1'b1;
      if (rd && i < 32) r[i] = data_i;
      #80 sclk_o = 1'b0;
    end
    #80 select_n_o = 1'b1;
    #200;
  endtask : xfer
endmodule : rcfg_host_model
`default_nettype wire

// ---- tb/rcfg_bank_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module rcfg_bank_tb;
  import rcfg_pkg::*;
  logic mclk_i = 0, rst_i = 1, sclk_i, select_n_in_i, host_d;
  logic power_off_n_in_i = 0, synth_locked_i = 0, adc_valid_i = 0;
  logic sample_ready_i = 0, mon = 0, dig = 1;
  rcfg_sample_s adc_sample_i = '0;
  logic serial_data_io_o, serial_data_io_oe_o, lock_indicator_out_o;
  logic adc_ready_o, sample_valid_o, monitor_out_pos_o, monitor_out_neg_o;
  logic inphase_sample_bit0_o, inphase_sample_bit1_o, amp_high_en_o;
  logic quadrature_sample_bit0_o, quadrature_sample_bit1_o, amp_low_en_o;
  wire logic serial_data_io_i = serial_data_io_oe_o ? serial_data_io_o
    : host_d;
  int n_fail = 0, compares = 0;
  logic [31:0] seed = 32'h6079, bank [11];
  rcfg_sample_s q [$];
  always #5 mclk_i = ~mclk_i;
  rcfg_bank rcfg_bank_inst (.*);
  rcfg_host_model rcfg_host_model_inst (.sclk_o(sclk_i),
    .select_n_o(select_n_in_i), .data_o(host_d),
    .data_i(serial_data_io_i));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // Writes while shut down are dropped by the device
  task automatic wr(input int a, input logic [31:0] w, input int n = 48);
    logic [31:0] r;
    // Keep every pin change off the sampling edge
    @(posedge mclk_i);
    #1;
    rcfg_host_model_inst.xfer(1'b0, a[11:0], w, r, n);
    if (a < 11 && n == 48 && power_off_n_in_i) bank[a] = w;
  endtask : wr
  task automatic rd(input int a);
    logic [31:0] r;
    @(posedge mclk_i);
    #1;
    rcfg_host_model_inst.xfer(1'b1, a[11:0], 32'h0, r, 48);
    check(r, a < 11 ? bank[a] : 32'h0);
  endtask : rd
  task automatic waitlock(input logic v);
    int n;
    n = 0;
    while (lock_indicator_out_o !== v && n < 20) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    check(lock_indicator_out_o, v);
    if (lock_indicator_out_o !== v) close_out();
  endtask : waitlock
  task automatic stream(input int n);
    rcfg_sample_s e;
    logic pend;
    pend = 0;
    for (int c = 0; c < n; c++) begin
      @(negedge mclk_i);
      if (pend) begin
        check({inphase_sample_bit1_o, inphase_sample_bit0_o,
          quadrature_sample_bit1_o, quadrature_sample_bit0_o},
          dig ? e : 4'h0);
        check({monitor_out_pos_o, monitor_out_neg_o},
          mon ? {e.inphase[1], ~e.inphase[1]} : 2'b00);
      end
      if (c == 9) check(adc_ready_o, 1'b0);
      pend = sample_valid_o && sample_ready_i;
      if (pend) e = q.pop_front();
      if (adc_valid_i && adc_ready_o) q.push_back(adc_sample_i);
      @(posedge mclk_i);
      #1;
      seed = lfsr(seed);
      adc_sample_i = seed[3:0];
      // Receiver stalls early so the buffer must refuse
      adc_valid_i = (seed[4] || c < 9) && c < n - 12;
      sample_ready_i = (seed[5] || c > n - 12) && c > 9;
    end
    check(q.size(), 0);
  endtask : stream
  ////////////////////////////////////////
  initial begin
    for (int a = 0; a < 11; a++) bank[a] = RCFG_RESET_BANK[a];
    repeat (4) @(posedge mclk_i);
    #1 rst_i = 0;
    power_off_n_in_i = 1;
    repeat (10) @(posedge mclk_i);
    for (int a = 0; a < 12; a++) rd(a);
    wr(0, {bank[0][31:30], 8'hfa, bank[0][21:0]});
    wr(9, {bank[9][31:25], 3'h3, bank[9][21:0]});
    check(bank[0], 32'hbea41603);
    check(bank[9], 32'h00c00002);
    rd(0);
    rd(9);
    wr(1, ~bank[1], 30);
    wr(11, 32'h5a5a5a5a);
    rd(1);
    rd(11);
    for (int m = 0; m < 4; m++) begin
      wr(0, {bank[0][31:15], m[1:0], bank[0][12:0]});
      check(amp_high_en_o, m == 0);
      check(amp_low_en_o, m == 1);
    end
    stream(300);
    mon = 1;
    wr(2, bank[2] | 32'h1);
    stream(300);
    // Digital output mode off: popped words leave the pins low
    dig = 0;
    wr(6, bank[6] & ~32'h08000000);
    stream(60);
    dig = 1;
    wr(6, bank[6] | 32'h08000000);
    synth_locked_i = 1;
    waitlock(1'b1);
    synth_locked_i = 0;
    waitlock(1'b0);
    synth_locked_i = 1;
    waitlock(1'b1);
    power_off_n_in_i = 0;
    repeat (10) @(posedge mclk_i);
    #1;
    check({lock_indicator_out_o, adc_ready_o, amp_low_en_o,
      amp_high_en_o, sample_valid_o}, 0);
    wr(3, 32'h12345678);
    power_off_n_in_i = 1;
    // Power pin needs a few cycles through its synchroniser
    repeat (10) @(posedge mclk_i);
    rd(3);
    // Digital mode register skipped so sample pins stay meaningful
    for (int a = 1; a < 11; a++) begin
      seed = lfsr(seed);
      if (a != 6) wr(a, seed);
    end
    for (int a = 0; a < 11; a++) rd(a);
    close_out();
  end
endmodule : rcfg_bank_tb
`default_nettype wire
